// file: rtl/cpmc_top.sv
// Charging port mode controller: select, DCP auto detection and CDP/SDP switch.
`timescale 1ns/1ps
`include "cpmc_cfg.svh"
module cpmc_top
  import cpmc_pkg::*;
#(
  parameter int unsigned SHORT_CYC = `CPMC_SHORT_CYC,
  parameter int unsigned CDP_HOLD_CYC = `CPMC_CDP_HOLD_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic charge_mode_select_pin,
  input wire logic client_response,
  input wire logic attach_detect,
  output cpmc_line_ctl_t line_ctl,
  output cpmc_state_t state
);

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic [2:0] sel_sync;
  logic [2:0] rsp_sync;
  logic [2:0] att_sync;
  logic sel_f;
  logic rsp_f;
  logic att_f;
  logic [2:0] next_sel_sync;
  logic [2:0] next_rsp_sync;
  logic [2:0] next_att_sync;
  logic next_sel_f;
  logic next_rsp_f;
  logic next_att_f;

  // Shift pins in; a filtered level changes only when stages two and three agree.
  always_comb begin
    next_sel_sync = {sel_sync[1:0], charge_mode_select_pin};
    next_rsp_sync = {rsp_sync[1:0], client_response};
    next_att_sync = {att_sync[1:0], attach_detect};
    next_sel_f = (sel_sync[2] == sel_sync[1]) ? sel_sync[2] : sel_f;
    next_rsp_f = (rsp_sync[2] == rsp_sync[1]) ? rsp_sync[2] : rsp_f;
    next_att_f = (att_sync[2] == att_sync[1]) ? att_sync[2] : att_f;
  end

  // Register the synchroniser stages.
  // Reset clears every stage, so a pin that idles high is seen one filter delay later.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_sync <= 3'h0;
      rsp_sync <= 3'h0;
      att_sync <= 3'h0;
      sel_f <= 1'b0;
      rsp_f <= 1'b0;
      att_f <= 1'b0;
    end else begin
      sel_sync <= next_sel_sync;
      rsp_sync <= next_rsp_sync;
      att_sync <= next_att_sync;
      sel_f <= next_sel_f;
      rsp_f <= next_rsp_f;
      att_f <= next_att_f;
    end
  end

  // ==========================================================
  // Detection state machine and CDP/SDP switch
  // ==========================================================
  cpmc_state_t next_state;
  logic [31:0] timer;
  logic [31:0] next_timer;
  logic cdp_active;
  logic next_cdp_active;
  cpmc_line_ctl_t next_line_ctl;

  // Next state, timer and CDP signature selection.
  always_comb begin
    next_state = state;
    next_timer = timer;
    next_cdp_active = cdp_active;
    if (sel_f == `CPMC_MODE_CDP) begin
      // The timer counts how long the charging signature has been shown while attached.
      next_state = CPMC_ST_PASS;
      if (!att_f) begin
        next_cdp_active = 1'b1; // Re-arm the charging signature when unplugged.
        next_timer = 32'h0;
      end else if (cdp_active) begin
        if (timer >= CDP_HOLD_CYC - 1) begin
          next_cdp_active = 1'b0; // Fall back to standard signature.
        end else begin
          next_timer = timer + 32'h1;
        end
      end
    end else begin
      next_cdp_active = 1'b1;
      unique case (state)
        CPMC_ST_PASS: begin
          next_state = CPMC_ST_DIV;
          next_timer = 32'h0;
        end
        CPMC_ST_DIV: begin
          if (rsp_f) begin
            next_state = CPMC_ST_SHORT;
            next_timer = 32'h0;
          end
        end
        CPMC_ST_SHORT: begin
          if (timer >= SHORT_CYC - 1) begin
            next_state = CPMC_ST_SHORT12;
          end else begin
            next_timer = timer + 32'h1;
          end
        end
        CPMC_ST_SHORT12: begin
          if (!att_f) begin
            next_state = CPMC_ST_DIV; // Detach restarts detection.
          end
        end
        default: begin
          next_state = CPMC_ST_DIV;
        end
      endcase
    end
  end

  // Line controls decoded from the next state.
  always_comb begin
    next_line_ctl = '0;
    unique case (next_state)
      CPMC_ST_PASS: begin
        next_line_ctl.data_pass = 1'b1;
        next_line_ctl.cdp_signature = next_cdp_active;
      end
      CPMC_ST_DIV: next_line_ctl.drive_div27 = 1'b1;
      CPMC_ST_SHORT: next_line_ctl.short_lines = 1'b1;
      CPMC_ST_SHORT12: begin
        next_line_ctl.short_lines = 1'b1;
        next_line_ctl.drive_1v2 = 1'b1;
      end
      default: next_line_ctl = '0;
    endcase
  end

  // Register state, timer and outputs.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= CPMC_ST_PASS;
      timer <= 32'h0;
      cdp_active <= 1'b1;
      line_ctl <= '0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      cdp_active <= next_cdp_active;
      line_ctl <= next_line_ctl;
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  // Line controls are decoded from next_state, so they change on the same edge as state.
  a_dcp_no_data: assert property (@(posedge clk) disable iff (!rst_n)
    (state != CPMC_ST_PASS) |-> !line_ctl.data_pass)
    else $error("Data passed in DCP mode.");
  a_div_drive: assert property (@(posedge clk) disable iff (!rst_n)
    (state == CPMC_ST_DIV) |-> (line_ctl.drive_div27 && !line_ctl.short_lines))
    else $error("Divider state not driving 2.7V.");
  a_short12_tied: assert property (@(posedge clk) disable iff (!rst_n)
    (state == CPMC_ST_SHORT12) |-> (line_ctl.short_lines && line_ctl.drive_1v2))
    else $error("1.2V state lines not tied.");
  a_short_tied: assert property (@(posedge clk) disable iff (!rst_n)
    (state == CPMC_ST_SHORT) |-> (line_ctl.short_lines && !line_ctl.drive_1v2))
    else $error("Short state lines not tied.");
  a_dcp_entry: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(state) == CPMC_ST_PASS && state != CPMC_ST_PASS) |-> state == CPMC_ST_DIV)
    else $error("DCP entry not in divider state.");
  a_short_order: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(state) == CPMC_ST_DIV && state == CPMC_ST_SHORT) |-> $past(rsp_f))
    else $error("Short state without client response.");
  a_short12_src: assert property (@(posedge clk) disable iff (!rst_n)
    (state == CPMC_ST_SHORT12 && $past(state) != CPMC_ST_SHORT12)
      |-> $past(state) == CPMC_ST_SHORT)
    else $error("1.2V state not reached from short state.");
  a_sel_mode: assert property (@(posedge clk) disable iff (!rst_n)
    (sel_f == `CPMC_MODE_CDP) |=> (state == CPMC_ST_PASS))
    else $error("CDP select did not give pass mode.");
  // Line controls stay cleared through reset and take the decode one edge after release.
  a_cdp_sig: assert property (@(posedge clk) disable iff (!rst_n)
    (state == CPMC_ST_PASS && $past(rst_n))
      |-> (line_ctl.data_pass && line_ctl.cdp_signature == cdp_active))
    else $error("CDP signature wrong.");
  a_rearm: assert property (@(posedge clk) disable iff (!rst_n)
    (sel_f == `CPMC_MODE_CDP && !att_f) |=> cdp_active)
    else $error("Signature not re-armed on detach.");
  // Sequencing checks: each state but CPMC_ST_SHORT12 is left only for the documented reason.
  a_pass_exit: assert property (@(posedge clk) disable iff (!rst_n)
    (state == CPMC_ST_PASS && sel_f == `CPMC_MODE_DCP) |=> (state == CPMC_ST_DIV))
    else $error("DCP select did not start detection.");
  a_div_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (state == CPMC_ST_DIV && sel_f == `CPMC_MODE_DCP && !rsp_f) |=> (state == CPMC_ST_DIV))
    else $error("Divider state left without client response.");
  a_short_len: assert property (@(posedge clk) disable iff (!rst_n)
    (state == CPMC_ST_SHORT && sel_f == `CPMC_MODE_DCP && timer < SHORT_CYC - 1)
      |=> (state == CPMC_ST_SHORT))
    else $error("Short state ended early.");
  a_sdp_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (state == CPMC_ST_PASS && sel_f == `CPMC_MODE_CDP && att_f && !cdp_active) |=> !cdp_active)
    else $error("Standard signature not held while attached.");
  a_dcp_no_sig: assert property (@(posedge clk) disable iff (!rst_n)
    (state != CPMC_ST_PASS) |-> !line_ctl.cdp_signature)
    else $error("Charging signature shown in DCP mode.");

endmodule : cpmc_top

// file: shared/cpmc_cfg.svh
// Timing and code constants for the charging port mode controller.
`ifndef CPMC_CFG_SVH
`define CPMC_CFG_SVH
`define CPMC_CLK_HZ 50000000
`define CPMC_SHORT_TIME_US 100
`define CPMC_SHORT_CYC ((`CPMC_SHORT_TIME_US * (`CPMC_CLK_HZ / 1000000)))
`define CPMC_CDP_HOLD_MS 1000
`define CPMC_CDP_HOLD_CYC ((`CPMC_CDP_HOLD_MS * (`CPMC_CLK_HZ / 1000)))
`define CPMC_MODE_CDP 1'b0
`define CPMC_MODE_DCP 1'b1
`endif

// file: shared/cpmc_pkg.sv
// Types for the charging port mode controller.
package cpmc_pkg;
  typedef enum logic [2:0] {
    CPMC_ST_PASS = 3'h0,
    CPMC_ST_DIV = 3'h1,
    CPMC_ST_SHORT = 3'h2,
    CPMC_ST_SHORT12 = 3'h3
  } cpmc_state_t;
  typedef struct packed {
    logic data_pass;
    logic drive_div27;
    logic short_lines;
    logic drive_1v2;
    logic cdp_signature;
  } cpmc_line_ctl_t;
endpackage : cpmc_pkg

// file: tb/cpmc_client_model.sv
// Portable device model attached to the charging port.
`timescale 1ns/1ps
module cpmc_client_model
  import cpmc_pkg::*;
(
  input wire logic clk,
  input wire logic plugged,
  input wire logic compliant,
  input wire cpmc_line_ctl_t line_ctl,
  output logic client_response,
  output logic attach_detect
);
  // ====
  // Answer
  logic saw_div;
  // Remember the divider signature until the cable is pulled.
  always_ff @(posedge clk) begin
    saw_div <= plugged & (saw_div | line_ctl.drive_div27);
  end
  // Only a compliant client answers; a legacy phone never does.
  assign client_response = plugged & compliant & saw_div;
  assign attach_detect = plugged;
endmodule : cpmc_client_model

// file: tb/cpmc_bench.sv
// Self-checking bench for the charging port mode controller.
`timescale 1ns/1ps
module cpmc_bench
  import cpmc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sel = 1'b0;
  logic plugged = 1'b0;
  logic compliant = 1'b0;
  logic client_response;
  logic attach_detect;
  cpmc_line_ctl_t line_ctl;
  cpmc_state_t state;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  int waited;
  // ====
  // Clock and instances
  always #10 clk = ~clk;
  cpmc_top #(.SHORT_CYC(10), .CDP_HOLD_CYC(20)) u_cpmc_top (.clk(clk), .rst_n(rst_n),
    .charge_mode_select_pin(sel), .client_response(client_response),
    .attach_detect(attach_detect), .line_ctl(line_ctl), .state(state));
  cpmc_client_model u_cpmc_client_model (.clk(clk), .plugged(plugged),
    .compliant(compliant), .line_ctl(line_ctl), .client_response(client_response),
    .attach_detect(attach_detect));
  // ====
  // Helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wait_state(input cpmc_state_t s);
    waited = 0;
    while (state !== s && waited < 40) begin
      @(negedge clk);
      waited++;
    end
  endtask : wait_state
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  // ====
  // Scenarios
  task automatic test_dcp_legacy();
    sel = 1'b1;
    plugged = 1'b1;
    wait_state(CPMC_ST_DIV);
    chk({state, line_ctl}, {CPMC_ST_DIV, 5'h08});
    repeat (20) @(negedge clk);
    chk({state, line_ctl}, {CPMC_ST_DIV, 5'h08});
  endtask : test_dcp_legacy
  task automatic test_dcp_compliant();
    plugged = 1'b0;
    repeat (6) @(negedge clk);
    compliant = 1'b1;
    plugged = 1'b1;
    wait_state(CPMC_ST_SHORT);
    chk({state, line_ctl}, {CPMC_ST_SHORT, 5'h04});
    wait_state(CPMC_ST_SHORT12);
    chk(8'(waited), 8'h0A);
    chk({state, line_ctl}, {CPMC_ST_SHORT12, 5'h06});
    plugged = 1'b0;
    wait_state(CPMC_ST_DIV);
    chk({state, line_ctl}, {CPMC_ST_DIV, 5'h08});
  endtask : test_dcp_compliant
  task automatic test_auto_switch();
    sel = 1'b0;
    wait_state(CPMC_ST_PASS);
    chk({state, line_ctl}, {CPMC_ST_PASS, 5'h11});
    plugged = 1'b1;
    repeat (10) @(negedge clk);
    chk({state, line_ctl}, {CPMC_ST_PASS, 5'h11});
    // Attach needs four edges to filter, then the hold count of 20 runs out.
    waited = 10;
    while (line_ctl.cdp_signature === 1'b1 && waited < 60) begin
      @(negedge clk);
      waited++;
    end
    chk(8'(waited), 8'h18);
    chk({state, line_ctl}, {CPMC_ST_PASS, 5'h10});
    plugged = 1'b0;
    repeat (8) @(negedge clk);
    chk({state, line_ctl}, {CPMC_ST_PASS, 5'h11});
  endtask : test_auto_switch
  // ====
  // Main sequence and hang guard
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    chk({state, line_ctl}, {CPMC_ST_PASS, 5'h11});
    test_dcp_legacy();
    test_dcp_compliant();
    test_auto_switch();
    tally_and_finish();
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      tally_and_finish();
    end
  end
endmodule : cpmc_bench
